/* File: evt_interrupt.sv */
// Purpose: event summary register, interrupt pin and abort commands
// Assumes: host strobes arrive from pins and are synchronised here
// Notes: setup register written through a plain port from the indirect decoder
module evt_interrupt
   import evt_pkg::*;
#(
   parameter int FRAME_PERIOD = FRAME_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // host port pins
   input wire logic [2:0] host_addr_lines,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic cs_n,
   output logic [7:0] host_data_out,
   output logic host_data_oe,
   output logic int_n,
   // global setup register from the indirect decoder
   input wire logic [7:0] setup_wdata,
   input wire logic setup_we,
   output logic [7:0] setup_r,
   // unit status and masks
   input wire src_s src,
   input wire mask_s msk,
   // status read in progress toward the units
   output logic status_freeze,
   // abort commands to the link controller
   output logic rx_abort,
   output logic tx_abort
);
   // ==========================================
   // pin synchronisers
   logic [1:0] rd_s_r, cs_s_r, wr_s_r;
   logic [2:0] addr_s1_r, addr_r;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rd_s_r <= 2'h3;
         cs_s_r <= 2'h3;
         wr_s_r <= 2'h3;
         addr_s1_r <= 3'h0;
         addr_r <= 3'h0;
      end else begin
         rd_s_r <= {rd_s_r[0], rd_n};
         cs_s_r <= {cs_s_r[0], cs_n};
         wr_s_r <= {wr_s_r[0], wr_n};
         addr_s1_r <= host_addr_lines;
         addr_r <= addr_s1_r;
      end
   end

   // both strobes low is illegal; such a cycle is not taken as a read
   logic rd_act, rd_prev_r, sum_read, sum_read_end;
   assign rd_act = !rd_s_r[1] && !cs_s_r[1] && wr_s_r[1];
   assign sum_read = rd_act && addr_r == ADDR_SUMMARY;
   assign status_freeze = rd_act && addr_r != ADDR_DATA;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rd_prev_r <= 1'b0;
      end else begin
         rd_prev_r <= sum_read;
      end
   end
   assign sum_read_end = rd_prev_r && !sum_read;

   // ==========================================
   // masked sources
   function automatic logic any_set(input logic [7:0] v, input logic [7:0] m);
      any_set = |(v & m);
   endfunction

   logic [7:0] live;
   always_comb begin
      live = 8'h00;
      live[SB_DTX] = src.dtx_thresh && msk.dlink_mask_one[0];
      live[SB_DRX] = src.drx_thresh && msk.dlink_mask_one[1];
      live[SB_DSTAT] = (src.dlink_status_one[0] && msk.dlink_mask_three[0]) ||
         (src.dlink_status_one[1] && msk.dlink_mask_one[3]) ||
         (src.dlink_status_one[6] && msk.dlink_mask_three[1]);
      live[SB_DERR] = any_set(src.dlink_error_register, msk.dlink_mask_two) ||
         (src.dlink_status_two[2] && msk.dlink_mask_three[6]);
      live[SB_BCH] = src.bch_ready && msk.mux_control_four[3];
      live[SB_LINE] = any_set({src.line_unit_status[7], src.line_unit_status[5:3], 4'h0},
         {msk.line_unit_mask[5], msk.line_unit_mask[4], msk.line_unit_mask[6],
         msk.line_unit_mask[3], 4'h0});
      live[SB_DSTAT2] = any_set({src.dlink_status_two[4:3], src.dlink_status_two[1:0], 4'h0},
         {msk.dlink_mask_three[5:2], 4'h0}) ||
         (src.dlink_status_two[7] && msk.extended_feature_ctrl[1]);
      live[SB_MFPP] = msk.peripheral_port_enable[7] &&
         (any_set(src.multiframe_status, {msk.multiframe_control[3:1], 5'h00}) ||
         any_set({1'b0, src.peripheral_port_status[6:0]},
         {1'b0, msk.peripheral_port_enable[6:0]}));
   end

   // ==========================================
   // summary register and pending hold
   logic [7:0] summary_r, held_r;

   // sticky; a read clears and defers new events to after the read
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         summary_r <= SUMMARY_RST;
         held_r <= SUMMARY_RST;
      end else if (sum_read) begin
         held_r <= held_r | live;
      end else if (sum_read_end) begin
         summary_r <= held_r | live;
         held_r <= SUMMARY_RST;
      end else begin
         summary_r <= summary_r | live;
      end
   end

   // read data captured at start of read
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         host_data_out <= 8'h00;
      end else if (sum_read && !rd_prev_r) begin
         host_data_out <= summary_r;
      end
   end
   assign host_data_oe = sum_read;

   // ==========================================
   // setup register
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         setup_r <= SETUP_RST;
      end else if (setup_we) begin
         setup_r <= setup_wdata;
      end
   end
   assign rx_abort = setup_r[SETUP_RX_ABORT];
   assign tx_abort = setup_r[SETUP_TX_ABORT];

   // ==========================================
   // interrupt pin, one assertion per frame
   logic tick, int_r, fired_r;

   evt_frame_timer #(.PERIOD(FRAME_PERIOD)) u_timer (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tick(tick)
   );

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         int_r <= 1'b0;
         fired_r <= 1'b0;
      end else begin
         if (tick) begin
            fired_r <= 1'b0;
         end
         // summary still holds the old byte in the cycle the read ends
         if (sum_read) begin
            int_r <= 1'b0;
         end else if (!int_r && !fired_r && !tick && |summary_r && !sum_read_end &&
               !setup_r[SETUP_INT_DIS]) begin
            int_r <= 1'b1;
            fired_r <= 1'b1;
         end
      end
   end
   // disable masks the pin and blocks new assertions; a pending assertion stays until read
   assign int_n = !(int_r && !setup_r[SETUP_INT_DIS]);

   // ==========================================
   // frame budget watch for the checks below
   logic int_d_r, int_rise;
   logic [1:0] rises_r;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         int_d_r <= 1'b0;
      end else begin
         int_d_r <= int_r;
      end
   end
   assign int_rise = int_r && !int_d_r;

   // saturates so a runaway pin still trips the check
   always_ff @(posedge mclk) begin
      if (sys_rst || tick) begin
         rises_r <= 2'h0;
      end else if (int_rise && rises_r != 2'h3) begin
         rises_r <= rises_r + 2'h1;
      end
   end

   // ==========================================
   // checks
   // reset
   a_int_after_reset: assert property (@(posedge mclk)
      sys_rst |=> int_n) else $error("int not high after reset");
   a_reset_clears: assert property (@(posedge mclk)
      sys_rst |=> (summary_r == SUMMARY_RST && held_r == SUMMARY_RST && !int_r))
      else $error("pending state survives reset");

   // read and clear
   a_read_releases_int: assert property (@(posedge mclk) disable iff (sys_rst)
      sum_read |=> int_n) else $error("int stays low after read");
   a_int_holds: assert property (@(posedge mclk) disable iff (sys_rst)
      (int_r && !sum_read) |=> int_r) else $error("int dropped without read");
   a_no_stale_int: assert property (@(posedge mclk) disable iff (sys_rst)
      sum_read_end |=> !int_r) else $error("int raised from cleared summary");
   a_read_clears: assert property (@(posedge mclk) disable iff (sys_rst)
      (sum_read_end && held_r == SUMMARY_RST && live == 8'h00) |=> summary_r == SUMMARY_RST)
      else $error("summary not cleared by read");
   a_data_capture: assert property (@(posedge mclk) disable iff (sys_rst)
      (sum_read && !rd_prev_r) |=> host_data_out == $past(summary_r))
      else $error("read data not the summary");

   // frame budget and pin
   a_one_per_frame: assert property (@(posedge mclk) disable iff (sys_rst)
      int_rise |-> rises_r == 2'h0) else $error("second int in frame");
   a_int_source: assert property (@(posedge mclk) disable iff (sys_rst)
      int_rise |-> $past(|summary_r && !setup_r[SETUP_INT_DIS]))
      else $error("int without enabled summary");
   a_disable_pin: assert property (@(posedge mclk) disable iff (sys_rst)
      setup_r[SETUP_INT_DIS] |-> int_n) else $error("int with pin disabled");

   // abort commands
   a_abort_follow: assert property (@(posedge mclk) disable iff (sys_rst)
      (setup_we && setup_wdata[SETUP_TX_ABORT]) |=> tx_abort)
      else $error("tx abort not issued");
   a_rx_abort_follow: assert property (@(posedge mclk) disable iff (sys_rst)
      (setup_we && setup_wdata[SETUP_RX_ABORT]) |=> rx_abort)
      else $error("rx abort not issued");
   a_abort_drop: assert property (@(posedge mclk) disable iff (sys_rst)
      (setup_we && !setup_wdata[SETUP_TX_ABORT] && !setup_wdata[SETUP_RX_ABORT]) |=>
      (!tx_abort && !rx_abort)) else $error("abort stays after clear");

   // hold and freeze
   a_held_applied: assert property (@(posedge mclk) disable iff (sys_rst)
      (sum_read_end && |held_r) |=> |summary_r) else $error("held event lost");
   a_held_capture: assert property (@(posedge mclk) disable iff (sys_rst)
      (sum_read && |live) |=> |held_r) else $error("event during read not held");
   a_frozen_summary: assert property (@(posedge mclk) disable iff (sys_rst)
      sum_read |=> $stable(summary_r)) else $error("summary moved during read");
   a_freeze_read: assert property (@(posedge mclk) disable iff (sys_rst)
      sum_read |-> status_freeze) else $error("no freeze on read");

   // source gating
   a_bit7_gate: assert property (@(posedge mclk) disable iff (sys_rst)
      !msk.peripheral_port_enable[7] |-> !live[SB_MFPP]) else $error("bit7 not masked");
   a_no_mask_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
      (msk == '0) |-> live == 8'h00) else $error("source live with all masks off");
   a_dtx_gate: assert property (@(posedge mclk) disable iff (sys_rst)
      !msk.dlink_mask_one[0] |-> !live[SB_DTX]) else $error("tx threshold not masked");
   a_drx_gate: assert property (@(posedge mclk) disable iff (sys_rst)
      !msk.dlink_mask_one[1] |-> !live[SB_DRX]) else $error("rx threshold not masked");
   a_bch_gate: assert property (@(posedge mclk) disable iff (sys_rst)
      !msk.mux_control_four[3] |-> !live[SB_BCH]) else $error("b channel not masked");
   a_line_gate: assert property (@(posedge mclk) disable iff (sys_rst)
      (msk.line_unit_mask == 8'h00) |-> !live[SB_LINE]) else $error("line status not masked");
   a_dstat2_gate: assert property (@(posedge mclk) disable iff (sys_rst)
      (msk.dlink_mask_three[5:2] == 4'h0 && !msk.extended_feature_ctrl[1]) |-> !live[SB_DSTAT2])
      else $error("dlink status two not masked");

   // every summary bit follows only its enabled source
   for (genvar gi = 0; gi < $bits(live); gi++) begin : g_sticky
      a_live_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
         (live[gi] && !sum_read && !sum_read_end) |=> summary_r[gi])
         else $error("event lost from summary");
      a_only_live: assert property (@(posedge mclk) disable iff (sys_rst)
         $rose(summary_r[gi]) |-> $past(live[gi] || held_r[gi]))
         else $error("summary bit without source");
   end

   c_int_fire: cover property (@(posedge mclk) $rose(int_r));
   c_read_clear: cover property (@(posedge mclk) sum_read ##1 !sum_read);
   c_held_event: cover property (@(posedge mclk) sum_read && |live);
   c_pin_disabled: cover property (@(posedge mclk) setup_r[SETUP_INT_DIS] && |summary_r);
   c_two_frames: cover property (@(posedge mclk) int_rise ##[1:60] int_rise);
endmodule

/* File: evt_pkg.sv */
// Purpose: shared constants and carriers for the subscriber event interrupt logic
// Assumes: single clock mclk at 40 MHz, synchronous active-high reset
// Notes: host port addresses follow the direct register map
package evt_pkg;
   localparam int CLK_MHZ = 40;
   localparam int FRAME_US = 125;
   localparam int FRAME_CYC = FRAME_US * CLK_MHZ;
   localparam logic [2:0] ADDR_SUMMARY = 3'h0;
   localparam logic [2:0] ADDR_DATA = 3'h1;
   localparam logic [7:0] SUMMARY_RST = 8'h00;
   localparam logic [7:0] SETUP_RST = 8'h00;
   localparam int SB_DTX = 0;
   localparam int SB_DRX = 1;
   localparam int SB_DSTAT = 2;
   localparam int SB_DERR = 3;
   localparam int SB_BCH = 4;
   localparam int SB_LINE = 5;
   localparam int SB_DSTAT2 = 6;
   localparam int SB_MFPP = 7;
   localparam int SETUP_INT_DIS = 2;
   localparam int SETUP_RX_ABORT = 6;
   localparam int SETUP_TX_ABORT = 7;

   // raw source status from the units
   typedef struct packed {
      logic dtx_thresh;
      logic drx_thresh;
      logic bch_ready;
      logic [7:0] dlink_status_one;
      logic [7:0] dlink_status_two;
      logic [7:0] dlink_error_register;
      logic [7:0] line_unit_status;
      logic [7:0] multiframe_status;
      logic [7:0] peripheral_port_status;
   } src_s;

   // mask registers held in the units
   typedef struct packed {
      logic [7:0] dlink_mask_one;
      logic [7:0] dlink_mask_two;
      logic [7:0] dlink_mask_three;
      logic [7:0] line_unit_mask;
      logic [7:0] mux_control_four;
      logic [7:0] multiframe_control;
      logic [7:0] peripheral_port_enable;
      logic [7:0] extended_feature_ctrl;
   } mask_s;
endpackage

/* File: evt_frame_timer.sv */
// Purpose: free-running frame period timer, one-cycle tick per frame
// Assumes: mclk at the rate given in the package
// Notes: period is a parameter so simulation may shorten it
module evt_frame_timer
   import evt_pkg::*;
#(
   parameter int PERIOD = FRAME_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // tick out
   output logic tick
);
   logic [15:0] cnt_r;

   always_ff @(posedge mclk) begin
      if (sys_rst || cnt_r == 16'(PERIOD - 1)) begin
         cnt_r <= 16'h0000;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end

   assign tick = (cnt_r == 16'(PERIOD - 1));
endmodule

/* File: host_model.sv */
// Purpose: host processor model reading the event summary over the pin port
// Assumes: pins change only after a falling edge of mclk
// Notes: setup writes come through the decoder port, so wr_n stays high
module host_model (
   // clock
   input wire logic mclk,
   // pins toward the device
   output logic [2:0] host_addr_lines,
   output logic rd_n,
   output logic wr_n,
   output logic cs_n,
   input wire logic host_data_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      host_addr_lines = 3'h7;
      rd_n = 1'b1;
      wr_n = 1'b1;
      cs_n = 1'b1;
   end
   // strobes held until the answer edge or at most 6 cycles, plus 2 + slow extra cycles
   task automatic rd(input logic [2:0] a, input int slow);
      int n;
      n = 0;
      @(negedge mclk);
      host_addr_lines = a;
      cs_n = 1'b0;
      rd_n = 1'b0;
      while (host_data_oe !== 1'b1 && n < 6) begin
         @(negedge mclk);
         n++;
      end
      repeat (2 + slow) @(negedge mclk);
      cs_n = 1'b1;
      rd_n = 1'b1;
      // released lines do not keep the old value
      host_addr_lines = ~a;
      repeat (4) @(negedge mclk);
   endtask
endmodule

/* File: tb.sv */
// Purpose: self-checking bench for the event summary and interrupt pin
// Assumes: frame period shortened to 20 cycles
// Notes: sources held long enough to span one frame tick
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import evt_pkg::*;
   localparam int FP = 20;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic rd_n, wr_n, cs_n, host_data_oe, int_n, setup_we, status_freeze, rx_abort, tx_abort;
   logic [2:0] host_addr_lines;
   logic [7:0] host_data_out, setup_wdata, setup_r, e;
   src_s src;
   mask_s msk;
   logic [15:0] lf = 16'hCE36;
   logic [7:0] exp_q[$];
   int fails = 0;
   int checks_done = 0;
   int cyc = 0;
   always #12.5 mclk = ~mclk;
   evt_interrupt #(.FRAME_PERIOD(FP)) evt_interrupt_inst (.mclk, .sys_rst, .host_addr_lines,
      .rd_n, .wr_n, .cs_n, .host_data_out, .host_data_oe, .int_n, .setup_wdata, .setup_we,
      .setup_r, .src, .msk, .status_freeze, .rx_abort, .tx_abort);
   host_model host_model_inst (.mclk, .host_addr_lines, .rd_n, .wr_n, .cs_n, .host_data_oe);
   // ==========================================
   // helpers
   function automatic logic [7:0] r8();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf[7:0];
   endfunction
   function automatic logic [7:0] summ(input src_s s, input mask_s m);
      logic [7:0] x;
      x[0] = s.dtx_thresh & m.dlink_mask_one[0];
      x[1] = s.drx_thresh & m.dlink_mask_one[1];
      x[2] = |(s.dlink_status_one[1:0] & {m.dlink_mask_one[3], m.dlink_mask_three[0]})
         | (s.dlink_status_one[6] & m.dlink_mask_three[1]);
      x[3] = |(s.dlink_error_register & m.dlink_mask_two)
         | (s.dlink_status_two[2] & m.dlink_mask_three[6]);
      x[4] = s.bch_ready & m.mux_control_four[3];
      x[5] = |({s.line_unit_status[7:3]} & {m.line_unit_mask[5], 1'b0,
         m.line_unit_mask[4], m.line_unit_mask[6], m.line_unit_mask[3]});
      x[6] = |({s.dlink_status_two[4:3], s.dlink_status_two[1:0]} & m.dlink_mask_three[5:2])
         | (s.dlink_status_two[7] & m.extended_feature_ctrl[1]);
      x[7] = m.peripheral_port_enable[7] & (|(s.multiframe_status[7:5]
         & m.multiframe_control[3:1]) | |(s.peripheral_port_status[6:0]
         & m.peripheral_port_enable[6:0]));
      return x;
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      checks_done++;
      if (seen !== want) begin
         fails++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wsetup(input logic [7:0] v);
      @(negedge mclk);
      setup_wdata = v;
      setup_we = 1'b1;
      @(negedge mclk);
      setup_we = 1'b0;
      repeat (2) @(negedge mclk);
   endtask
   // ==========================================
   // watcher: each summary answer against the oldest note
   always begin
      @(negedge mclk iff host_data_oe === 1'b1);
      @(negedge mclk);
      if (exp_q.size() == 0) begin
         fails++;
         $display("BAD %0t answer without a summary read", $time);
      end else
         chk(host_data_out, exp_q.pop_front());
      wait (host_data_oe !== 1'b1);
   end
   // hang guard, run needs about 1700 cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         $display("BAD %0t timeout", $time);
         conclude();
      end
   end
   // ==========================================
   // main sequence
   initial begin
      src = '0;
      msk = '0;
      setup_wdata = 8'h00;
      setup_we = 1'b0;
      repeat (10) @(negedge mclk);
      sys_rst = 1'b0;
      chk(8'(int_n), 8'h01);
      chk(setup_r, SETUP_RST);
      $display("test reset done");
      for (int i = 0; i < 40; i++) begin
         for (int b = 0; b < 64; b++) begin
            msk[b] = ^r8();
            if (b < $bits(src_s))
               src[b] = r8() < 8'h18;
         end
         repeat (30) @(negedge mclk);
         e = summ(src, msk);
         chk(8'(int_n), 8'(e == 8'h00));
         src = '0;
         exp_q.push_back(e);
         host_model_inst.rd(ADDR_SUMMARY, i % 3);
         chk(8'(int_n), 8'h01);
      end
      $display("test source map done");
      msk = '1;
      exp_q.push_back(8'h00);
      fork
         host_model_inst.rd(ADDR_SUMMARY, 2);
         begin
            repeat (3) @(negedge mclk);
            chk(8'(status_freeze), 8'h01);
            src.dtx_thresh = 1'b1;
            @(negedge mclk);
            src = '0;
         end
      join
      exp_q.push_back(8'h01);
      host_model_inst.rd(ADDR_SUMMARY, 0);
      fork
         host_model_inst.rd(3'h3, 0);
         begin
            repeat (3) @(negedge mclk);
            chk(8'(status_freeze), 8'h01);
         end
      join
      $display("test read hold done");
      wsetup(8'h04);
      src.bch_ready = 1'b1;
      repeat (30) @(negedge mclk);
      chk(8'(int_n), 8'h01);
      src = '0;
      exp_q.push_back(8'h10);
      host_model_inst.rd(ADDR_SUMMARY, 1);
      wsetup(8'hC0);
      chk(8'({rx_abort, tx_abort}), 8'h03);
      chk(setup_r, 8'hC0);
      $display("test setup done");
      src.drx_thresh = 1'b1;
      repeat (30) @(negedge mclk);
      src = '0;
      sys_rst = 1'b1;
      repeat (2) @(negedge mclk);
      sys_rst = 1'b0;
      chk(8'({int_n, rx_abort, tx_abort}), 8'h04);
      exp_q.push_back(SUMMARY_RST);
      host_model_inst.rd(ADDR_SUMMARY, 0);
      $display("test reset mid run done");
      conclude();
   end
endmodule
